// File: logic/burst_sram_pkg.sv
// Operation
// (RULE1) Both output clocks high at power on: single-clock strap
// (RULE2) Read and write ports work independently
// (RULE3) Read after write returns newest data
// (RULE4) Both selected from idle: read first
// (RULE5) Both selected after read: write starts
// (RULE6) Both selected after write: read starts
// (RULE7) Both held selected: alternate, starting with read
// (RULE8) Port selects sampled on positive clock rise only
// (RULE9) Deselect affects one port; bursts finish first
// (RULE10) Recalibrate output impedance every 1024 cycles
// (RULE11) Two free-running echo clocks follow output clocks; in single-clock mode they follow the input clocks instead
// (RULE12) DLL locks after 1024 stable input clocks
// (RULE13) Clock stopped 30 ns or more resets DLL
// (RULE14) Low DLL-off pin disables the DLL
// (RULE15) Write: address at t, four words t+1, t+2
// (RULE16) Read: words from complementary clock t+1 to t+3
// (RULE17) Powers up deselected, read outputs high impedance
// (RULE18) Back-to-back same-kind requests: second one ignored
// (RULE19) Select used last rise is don't-care next rise
// (RULE20) Stopped clocks held high for fastest restart
// (RULE21) Read deselect: finish, float after positive clock
// (RULE22) Deasserted byte select keeps stored byte
// (RULE23) Both deselected: ignore write data, outputs float
`default_nettype none
package burst_sram_pkg;
	localparam int DATA_W = 18;
	localparam int BYTE_W = 9;
	localparam int NBYTE = 2;
	localparam int ADDR_W = 6;
	localparam int MEM_AW = ADDR_W + 2;
	localparam int BURST = 4;
	localparam int FIFO_DEPTH = 16;
	localparam int CLK_PERIOD_NS = 10;
	localparam int DLL_STOP_NS = 30;
	localparam int DLL_STOP_CYC =
		(DLL_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [10:0] DLL_LOCK_CYC = 11'h400;
	localparam logic [9:0] ZQ_CAL_LAST = 10'h3FF;

	// Last operation started on a positive clock rise
	typedef enum logic [1:0] {
		LAST_NONE = 2'h0,
		LAST_RD = 2'h1,
		LAST_WR = 2'h3
	} last_op_e;

	// Replace only the bytes whose active-low select is low
	function automatic logic [DATA_W-1:0] byte_merge(
		input logic [DATA_W-1:0] old_w,
		input logic [DATA_W-1:0] new_w,
		input logic [NBYTE-1:0] sel_n);
		logic [DATA_W-1:0] r;
		r = old_w;
		for (int b = 0; b < NBYTE; b++) begin
			if (!sel_n[b]) begin
				r[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
			end
		end
		return r;
	endfunction : byte_merge

	// Word index of a burst from its one-hot beat slot
	function automatic logic [1:0] beat_idx(input logic [3:0] hot);
		logic [1:0] i;
		i = 2'h0;
		if (hot[1]) begin
			i = 2'h1;
		end else if (hot[2]) begin
			i = 2'h2;
		end else if (hot[3]) begin
			i = 2'h3;
		end
		return i;
	endfunction : beat_idx
endpackage : burst_sram_pkg
`default_nettype wire

// File: logic/burst_sram_if.sv
`timescale 1ns/1ns
`default_nettype none
interface burst_sram_if;
	logic k_pos;
	logic k_neg;
	logic c_pos;
	logic c_neg;
	logic read_port_select_n;
	logic write_port_select_n;
	logic [burst_sram_pkg::ADDR_W-1:0] addr;
	logic [burst_sram_pkg::DATA_W-1:0] wdata;
	logic [burst_sram_pkg::NBYTE-1:0] byte_write_select_n;
	logic dll_off_n;
	logic [burst_sram_pkg::DATA_W-1:0] rdata;
	logic rdata_oe;
	logic echo_clock_pos;
	logic echo_clock_neg;
	logic dll_locked;

	modport dev (
		input k_pos, k_neg, c_pos, c_neg,
		input read_port_select_n, write_port_select_n,
		input addr, wdata, byte_write_select_n, dll_off_n,
		output rdata, rdata_oe, echo_clock_pos, echo_clock_neg,
		output dll_locked
	);
	modport host (
		output k_pos, k_neg, c_pos, c_neg,
		output read_port_select_n, write_port_select_n,
		output addr, wdata, byte_write_select_n, dll_off_n,
		input rdata, rdata_oe, echo_clock_pos, echo_clock_neg,
		input dll_locked
	);
endinterface : burst_sram_if
`default_nettype wire

// File: logic/sync_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module sync_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [0:DEPTH-1];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_d;
	logic push;
	logic pop;

	// Flags are registered from the next count, so they never lie
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign cnt_d = count + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem_q[rp_q];

	// Storage; pointers wrap because depth is a power of two
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	// Pointers, count and flags
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wp_q <= '0;
			rp_q <= '0;
			count <= '0;
			in_ready <= 1'h0;
			out_valid <= 1'h0;
		end else begin
			wp_q <= wp_q + AW'(push);
			rp_q <= rp_q + AW'(pop);
			count <= cnt_d;
			in_ready <= cnt_d != (AW+1)'(DEPTH);
			out_valid <= cnt_d != '0;
		end
	end
endmodule : sync_fifo
`default_nettype wire

// File: logic/burst_sram_host.sv
`timescale 1ns/1ns
`default_nettype none
module burst_sram_host (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Link to the memory
	burst_sram_if.host lnk,
	// Command port
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [burst_sram_pkg::ADDR_W-1:0] cmd_addr,
	output logic cmd_ready,
	// Write data port
	input wire logic wr_valid,
	input wire logic [burst_sram_pkg::DATA_W-1:0] wr_data,
	input wire logic [burst_sram_pkg::NBYTE-1:0] wr_byte_n,
	output logic wr_ready,
	// Read data port
	output logic rd_valid,
	output logic [burst_sram_pkg::DATA_W-1:0] rd_data,
	// Clock and mode control
	input wire logic stop_clocks,
	input wire logic single_clock,
	input wire logic dll_enable,
	output logic link_ready
);
	localparam int FW = burst_sram_pkg::DATA_W + burst_sram_pkg::NBYTE;
	logic [FW-1:0] f_out;
	logic [$clog2(burst_sram_pkg::FIFO_DEPTH):0] f_count;
	logic f_valid;
	logic f_pop;
	logic single_q;
	logic strap_q;
	logic pend_v_q;
	logic pend_w_q;
	logic [burst_sram_pkg::ADDR_W-1:0] pend_a_q;
	logic pend_v_d;
	logic issue;
	logic [5:1] wr_sr_q;
	logic [8:1] rd_sr_q;
	burst_sram_pkg::last_op_e last_q;

	// Write words wait here; a full buffer stalls the user side
	sync_fifo #(
		.WIDTH(FW),
		.DEPTH(burst_sram_pkg::FIFO_DEPTH)
	) u_wr_fifo (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data({wr_byte_n, wr_data}),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_out),
		.count(f_count)
	);

	// Issue only ahead of a rise, never twice the same kind in a row
	always_comb begin
		issue = pend_v_q & ~lnk.k_pos & ~stop_clocks & link_ready;
		if (pend_w_q) begin
			issue = issue & (last_q != burst_sram_pkg::LAST_WR) &
				(f_count >= ($bits(f_count))'(burst_sram_pkg::BURST)); // (RULE18)
		end else begin
			issue = issue & (last_q != burst_sram_pkg::LAST_RD); // (RULE18)
		end
		pend_v_d = issue ? 1'h0 : (pend_v_q | (cmd_valid & cmd_ready));
	end
	assign f_pop = f_valid & (|wr_sr_q[5:2]);

	// Strap is fixed at the first edge after reset
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			single_q <= 1'h0;
			strap_q <= 1'h0;
		end else if (!strap_q) begin
			single_q <= single_clock; // (RULE1)
			strap_q <= 1'h1;
		end
	end

	// Input and output clock pairs; stopped clocks rest high
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lnk.k_pos <= 1'h0;
			lnk.k_neg <= 1'h1;
			lnk.c_pos <= 1'h1;
			lnk.c_neg <= 1'h1;
		end else if (stop_clocks) begin
			lnk.k_pos <= 1'h1; // (RULE20)
			lnk.k_neg <= 1'h1;
			lnk.c_pos <= 1'h1;
			lnk.c_neg <= 1'h1;
		end else begin
			lnk.k_pos <= ~lnk.k_pos;
			lnk.k_neg <= lnk.k_pos;
			lnk.c_pos <= (strap_q ? single_q : single_clock) | ~lnk.k_pos; // (RULE1)
			lnk.c_neg <= (strap_q ? single_q : single_clock) | lnk.k_pos;
		end
	end

	// Pending command and last started kind
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pend_v_q <= 1'h0;
			pend_w_q <= 1'h0;
			pend_a_q <= '0;
			cmd_ready <= 1'h0;
			last_q <= burst_sram_pkg::LAST_NONE;
			link_ready <= 1'h0;
			lnk.dll_off_n <= 1'h0;
		end else begin
			pend_v_q <= pend_v_d;
			cmd_ready <= ~pend_v_d;
			link_ready <= ~dll_enable | lnk.dll_locked;
			lnk.dll_off_n <= dll_enable;
			if (cmd_valid & cmd_ready) begin
				pend_w_q <= cmd_write;
				pend_a_q <= cmd_addr;
			end
			if (!lnk.k_pos && !stop_clocks) begin
				case ({issue, pend_w_q})
					2'h2: last_q <= burst_sram_pkg::LAST_RD;
					2'h3: last_q <= burst_sram_pkg::LAST_WR;
					default: last_q <= burst_sram_pkg::LAST_NONE;
				endcase
			end
		end
	end

	// Selects for one edge around the rise, then idle high
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lnk.read_port_select_n <= 1'h1;
			lnk.write_port_select_n <= 1'h1;
			lnk.addr <= '0;
			wr_sr_q <= '0;
			rd_sr_q <= '0;
		end else begin
			lnk.read_port_select_n <= ~(issue & ~pend_w_q);
			lnk.write_port_select_n <= ~(issue & pend_w_q);
			if (issue) begin
				lnk.addr <= pend_a_q;
			end
			wr_sr_q <= {wr_sr_q[4:1], issue & pend_w_q};
			rd_sr_q <= {rd_sr_q[7:1], issue & ~pend_w_q};
		end
	end

	// Write words on four successive edges after the address
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lnk.wdata <= '0;
			lnk.byte_write_select_n <= '1;
		end else if (f_pop) begin
			lnk.wdata <= f_out[burst_sram_pkg::DATA_W-1:0]; // (RULE15)
			lnk.byte_write_select_n <= f_out[FW-1:burst_sram_pkg::DATA_W];
		end else begin
			lnk.wdata <= '0;
			lnk.byte_write_select_n <= '1;
		end
	end

	// Read words captured one edge after the memory drives them
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rd_valid <= 1'h0;
			rd_data <= '0;
		end else begin
			rd_valid <= |rd_sr_q[8:5]; // (RULE16)
			rd_data <= lnk.rdata;
		end
	end
endmodule : burst_sram_host
`default_nettype wire

// File: logic/burst_sram_device.sv
`timescale 1ns/1ns
`default_nettype none
module burst_sram_device (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Link to the controller
	burst_sram_if.dev lnk,
	// Local status
	output logic single_mode,
	output logic imp_recal_pulse
);
	logic [burst_sram_pkg::DATA_W-1:0] mem_q [0:2**burst_sram_pkg::MEM_AW-1];

	logic k_prev_q;
	logic c_prev_q;
	logic k_rise;
	logic c_rise;
	logic out_rise;
	logic strap_q;

	burst_sram_pkg::last_op_e last_q;
	logic rd_req;
	logic wr_req;
	logic start_rd;
	logic start_wr;

	logic [5:1] wr_sr_q;
	logic [6:1] rd_sr_q;
	logic [burst_sram_pkg::ADDR_W-1:0] wa_pend_q;
	logic [burst_sram_pkg::ADDR_W-1:0] wa_act_q;
	logic [burst_sram_pkg::ADDR_W-1:0] ra_pend_q;
	logic [burst_sram_pkg::ADDR_W-1:0] ra_act_q;
	logic wr_beat;
	logic rd_beat;
	logic fwd;
	logic [burst_sram_pkg::MEM_AW-1:0] wr_idx;
	logic [burst_sram_pkg::MEM_AW-1:0] rd_idx;
	logic [burst_sram_pkg::DATA_W-1:0] wr_word;

	logic [1:0] stop_cnt_q;
	logic clk_stopped;
	logic [10:0] lock_cnt_q;
	logic [9:0] cal_cnt_q;

	// Clock edge detection; the pins come from logic on ref_clk
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			k_prev_q <= 1'h0;
			c_prev_q <= 1'h0;
		end else begin
			k_prev_q <= lnk.k_pos;
			c_prev_q <= lnk.c_pos;
		end
	end
	assign k_rise = lnk.k_pos & ~k_prev_q; // (RULE8)
	assign c_rise = lnk.c_pos & ~c_prev_q;
	assign out_rise = single_mode ? k_rise : c_rise; // (RULE11)

	// Strap caught at the first input clock rise, then frozen
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			strap_q <= 1'h0;
			single_mode <= 1'h0;
		end else if (k_rise && !strap_q) begin
			single_mode <= lnk.c_pos & lnk.c_neg; // (RULE1)
			strap_q <= 1'h1;
		end
	end

	// A select used on the last rise is ignored on this one
	always_comb begin
		rd_req = k_rise & ~lnk.read_port_select_n &
			(last_q != burst_sram_pkg::LAST_RD); // (RULE18) (RULE19)
		wr_req = k_rise & ~lnk.write_port_select_n &
			(last_q != burst_sram_pkg::LAST_WR); // (RULE18) (RULE19)
		start_rd = rd_req; // (RULE4) (RULE6)
		start_wr = wr_req & ~rd_req; // (RULE5)
	end

	// Arbitration history, updated on each positive rise only
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			last_q <= burst_sram_pkg::LAST_NONE; // (RULE17)
		end else if (k_rise) begin
			case ({start_rd, start_wr})
				2'h2: last_q <= burst_sram_pkg::LAST_RD; // (RULE7)
				2'h1: last_q <= burst_sram_pkg::LAST_WR; // (RULE7)
				default: last_q <= burst_sram_pkg::LAST_NONE;
			endcase
		end
	end

	// Burst slot shifters; each port keeps its own address (RULE2)
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wr_sr_q <= '0;
			rd_sr_q <= '0;
		end else begin
			wr_sr_q <= {wr_sr_q[4:1], start_wr}; // (RULE15)
			rd_sr_q <= {rd_sr_q[5:1], start_rd}; // (RULE16)
		end
	end

	// Addresses: a new start may land while the prior burst ends,
	// so the active copy moves only just before the first beat
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wa_pend_q <= '0;
			wa_act_q <= '0;
			ra_pend_q <= '0;
			ra_act_q <= '0;
		end else begin
			if (start_wr) begin
				wa_pend_q <= lnk.addr;
			end
			if (wr_sr_q[1]) begin
				wa_act_q <= wa_pend_q;
			end
			if (start_rd) begin
				ra_pend_q <= lnk.addr;
			end
			if (rd_sr_q[2]) begin
				ra_act_q <= ra_pend_q;
			end
		end
	end

	// Beat decode: writes on slots 2..5, reads on slots 3..6
	assign wr_beat = |wr_sr_q[5:2]; // (RULE9) (RULE23)
	assign rd_beat = |rd_sr_q[6:3]; // (RULE9)
	assign wr_idx = {wa_act_q, burst_sram_pkg::beat_idx(wr_sr_q[5:2])};
	assign rd_idx = {ra_act_q, burst_sram_pkg::beat_idx(rd_sr_q[6:3])};
	assign wr_word = burst_sram_pkg::byte_merge(mem_q[wr_idx], lnk.wdata,
		lnk.byte_write_select_n); // (RULE22)
	assign fwd = wr_beat & (wr_idx == rd_idx);

	// Array write, one word per beat, masked by byte selects
	always_ff @(posedge ref_clk) begin
		if (wr_beat) begin
			mem_q[wr_idx] <= wr_word; // (RULE22)
		end
	end

	// Read word register; a same-edge write is forwarded
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lnk.rdata <= '0;
		end else if (rd_beat) begin
			lnk.rdata <= fwd ? wr_word : mem_q[rd_idx]; // (RULE3)
		end
	end

	// Output enable floats at the next positive output rise
	// after the last word, so depth-expanded parts hand over cleanly
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lnk.rdata_oe <= 1'h0; // (RULE17)
		end else if (rd_beat) begin
			lnk.rdata_oe <= 1'h1; // (RULE16)
		end else if (out_rise) begin
			lnk.rdata_oe <= 1'h0; // (RULE21) (RULE23)
		end
	end

	// Echo clocks run free from the output or input clock pair
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lnk.echo_clock_pos <= 1'h0;
			lnk.echo_clock_neg <= 1'h1;
		end else if (single_mode) begin
			lnk.echo_clock_pos <= lnk.k_pos; // (RULE11)
			lnk.echo_clock_neg <= lnk.k_neg;
		end else begin
			lnk.echo_clock_pos <= lnk.c_pos; // (RULE11)
			lnk.echo_clock_neg <= lnk.c_neg;
		end
	end

	// Stop detector: saturating count of edges without a toggle
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			stop_cnt_q <= 2'h0;
		end else if (lnk.k_pos != k_prev_q) begin
			stop_cnt_q <= 2'h0;
		end else if (!clk_stopped) begin
			stop_cnt_q <= stop_cnt_q + 2'h1;
		end
	end
	assign clk_stopped =
		stop_cnt_q >= 2'(burst_sram_pkg::DLL_STOP_CYC); // (RULE13)

	// DLL lock counter; no explicit reset is needed for a new rate
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lock_cnt_q <= 11'h000;
			lnk.dll_locked <= 1'h0;
		end else if (!lnk.dll_off_n) begin
			lock_cnt_q <= 11'h000; // (RULE14)
			lnk.dll_locked <= 1'h0;
		end else if (clk_stopped) begin
			lock_cnt_q <= 11'h000; // (RULE13)
			lnk.dll_locked <= 1'h0;
		end else if (k_rise) begin
			if (lock_cnt_q != burst_sram_pkg::DLL_LOCK_CYC) begin
				lock_cnt_q <= lock_cnt_q + 11'h001;
			end
			// Counter parks at the lock count, so compare by range
			lnk.dll_locked <= lock_cnt_q >=
				burst_sram_pkg::DLL_LOCK_CYC - 11'h001; // (RULE12)
		end
	end

	// Impedance recalibration strobe, one pulse per 1024 rises;
	// a stopped clock simply pauses the interval
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cal_cnt_q <= 10'h000;
			imp_recal_pulse <= 1'h0;
		end else begin
			imp_recal_pulse <= k_rise &&
				cal_cnt_q == burst_sram_pkg::ZQ_CAL_LAST; // (RULE10)
			if (k_rise) begin
				cal_cnt_q <= cal_cnt_q + 10'h001;
			end
		end
	end
endmodule : burst_sram_device
`default_nettype wire

// File: bench/burst_sram_properties.sv
`timescale 1ns/1ns
`default_nettype none
module burst_sram_properties (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Link signals
	input wire logic k_pos,
	input wire logic k_neg,
	input wire logic c_pos,
	input wire logic c_neg,
	input wire logic read_port_select_n,
	input wire logic write_port_select_n,
	input wire logic [burst_sram_pkg::NBYTE-1:0] byte_write_select_n,
	input wire logic dll_off_n,
	input wire logic rdata_oe,
	input wire logic echo_clock_pos,
	input wire logic echo_clock_neg,
	input wire logic dll_locked
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic k_q, strap_q, known_q, k_rise;
	logic [3:0] rd_age_q, wr_age_q, stall_q;
	logic [10:0] rises_q;
	assign k_rise = k_pos & ~k_q;
	// Edge ages since each start and the clock history; saturate, no wrap
	always_ff @(posedge ref_clk) begin
		k_q <= nrst & k_pos;
		if (!nrst) begin
			{rd_age_q, wr_age_q, stall_q} <= 12'hFFF;
			{strap_q, known_q} <= 2'h0;
			rises_q <= 11'h000;
		end else begin
			rd_age_q <= (k_rise & ~read_port_select_n) ? 4'h0 :
				rd_age_q + {3'h0, rd_age_q != 4'hF};
			wr_age_q <= (k_rise & ~write_port_select_n) ? 4'h0 :
				wr_age_q + {3'h0, wr_age_q != 4'hF};
			stall_q <= (k_pos != k_q) ? 4'h0 :
				stall_q + {3'h0, stall_q != 4'hF};
			if (!dll_off_n || stall_q >= 4'h3) begin
				rises_q <= 11'h000;
			end else if (k_rise && rises_q != 11'h7FF) begin
				rises_q <= rises_q + 11'h001;
			end
			if (k_rise && !known_q) begin
				// Strap needs both output clocks high, not one
				{strap_q, known_q} <= {c_pos & c_neg, 1'h1};
			end
		end
	end
	sequence s_read_start;
		k_rise && !read_port_select_n;
	endsequence
	sequence s_words_out;
		##4 rdata_oe [*4];
	endsequence
	a_sel_on_rise: assert property (
		(!read_port_select_n || !write_port_select_n) |-> k_rise)
		else $error("port select low off a k rise");
	a_read_spacing: assert property (
		s_read_start |-> ##2 read_port_select_n)
		else $error("reads on consecutive k rises");
	a_write_spacing: assert property (
		k_rise && !write_port_select_n |-> ##2 write_port_select_n)
		else $error("writes on consecutive k rises");
	a_read_words_out: assert property (
		s_read_start |-> s_words_out)
		else $error("read words not driven on time");
	a_read_float: assert property (
		rdata_oe |-> rd_age_q <= 4'h7)
		else $error("read outputs driven with no read");
	a_write_beats: assert property (
		byte_write_select_n != '1 |-> wr_age_q inside {[1:4]})
		else $error("byte selects active outside write beats");
	a_echo_follow: assert property (
		known_q && $past(known_q) |->
		echo_clock_pos == $past(strap_q ? k_pos : c_pos) &&
		echo_clock_neg == $past(strap_q ? k_neg : c_neg))
		else $error("echo clock off its reference");
	a_lock_count: assert property (
		$rose(dll_locked) |-> rises_q inside {[1023:1025]})
		else $error("lock after wrong number of k rises");
	a_lock_held: assert property (
		dll_locked && dll_off_n && stall_q < 4'h3 |=> dll_locked)
		else $error("lock lost with clock running");
	a_dll_off_unlock: assert property (
		!dll_off_n |=> !dll_locked)
		else $error("lock held with loop disabled");
	a_stall_unlock: assert property (
		stall_q >= 4'h5 |-> !dll_locked)
		else $error("lock held with clock stopped");
endmodule : burst_sram_properties
`default_nettype wire

// File: bench/dual_port_burst_sram_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module dual_port_burst_sram_control_bench;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic wr_valid = 1'b0;
	logic stop_clocks = 1'b0;
	logic single_clock = 1'b0;
	logic dll_enable = 1'b1;
	logic [5:0] cmd_addr = 6'h00;
	logic [17:0] wr_data = 18'h00000;
	logic [1:0] wr_byte_n = 2'h3;
	logic [17:0] rd_data;
	logic cmd_ready, wr_ready, rd_valid, link_ready;
	logic single_mode, imp_recal_pulse;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	burst_sram_if lnk ();
	burst_sram_host u_burst_sram_host (.ref_clk, .nrst, .lnk(lnk),
		.cmd_valid, .cmd_write, .cmd_addr, .cmd_ready, .wr_valid,
		.wr_data, .wr_byte_n, .wr_ready, .rd_valid, .rd_data,
		.stop_clocks, .single_clock, .dll_enable, .link_ready);
	burst_sram_device u_burst_sram_device (.ref_clk, .nrst, .lnk(lnk),
		.single_mode, .imp_recal_pulse);
	burst_sram_properties u_burst_sram_properties (.ref_clk, .nrst,
		.k_pos(lnk.k_pos), .c_pos(lnk.c_pos),
		.read_port_select_n(lnk.read_port_select_n),
		.write_port_select_n(lnk.write_port_select_n),
		.byte_write_select_n(lnk.byte_write_select_n),
		.dll_off_n(lnk.dll_off_n), .rdata_oe(lnk.rdata_oe),
		.echo_clock_pos(lnk.echo_clock_pos), .dll_locked(lnk.dll_locked),
		.k_neg(lnk.k_neg), .c_neg(lnk.c_neg),
		.echo_clock_neg(lnk.echo_clock_neg));
	always #5 ref_clk = ~ref_clk;
	// Hang guard; the whole run needs about 8300 edges
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [17:0] e, g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic do_reset(input logic single);
		@(negedge ref_clk);
		nrst = 1'b0;
		single_clock = single;
		repeat (12) @(negedge ref_clk);
		nrst = 1'b1;
	endtask : do_reset
	// Four words in push order; ready seen at a falling edge holds to the rise
	task automatic push4(input logic [17:0] base, input logic [1:0] b);
		for (int i = 0; i < 4; i++) begin
			@(negedge ref_clk);
			while (wr_ready !== 1'b1) @(negedge ref_clk);
			wr_valid = 1'b1;
			wr_data = base + 18'(i);
			wr_byte_n = b;
		end
		@(negedge ref_clk);
		wr_valid = 1'b0;
	endtask : push4
	task automatic issue(input logic w, input logic [5:0] a);
		@(negedge ref_clk);
		while (cmd_ready !== 1'b1) @(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
	endtask : issue
	task automatic read_chk(input logic [5:0] a, input logic [17:0] e [4]);
		issue(1'b0, a);
		for (int i = 0; i < 4; i++) begin
			do @(negedge ref_clk); while (rd_valid !== 1'b1);
			check("read word", e[i], rd_data);
		end
	endtask : read_chk
	task automatic s_lock();
		check("outputs driven", 1'b0, lnk.rdata_oe);
		repeat (2000) @(negedge ref_clk);
		check("early ready", 1'b0, link_ready);
		repeat (100) @(negedge ref_clk);
		check("ready after lock", 1'b1, link_ready);
	endtask : s_lock
	// Partial second write keeps the untouched upper byte
	task automatic s_bytes();
		logic [17:0] e [4];
		push4(18'h2AA00, 2'h0);
		issue(1'b1, 6'h05);
		push4(18'h15570, 2'h2);
		issue(1'b1, 6'h05);
		for (int i = 0; i < 4; i++) begin
			e[i] = {9'h155, 9'h170 + 9'(i)};
		end
		read_chk(6'h05, e);
	endtask : s_bytes
	// Read issued right behind a write to the same burst
	task automatic s_fresh();
		logic [17:0] e [4];
		push4(18'h0F0F0, 2'h0);
		issue(1'b1, 6'h3F);
		for (int i = 0; i < 4; i++) begin
			e[i] = 18'h0F0F0 + 18'(i);
		end
		read_chk(6'h3F, e);
	endtask : s_fresh
	task automatic s_recal();
		int gap;
		gap = 0;
		do @(negedge ref_clk); while (imp_recal_pulse !== 1'b1);
		do begin
			@(negedge ref_clk);
			gap++;
		end while (imp_recal_pulse !== 1'b1);
		check("recal spacing", 18'h00800, 18'(gap));
	endtask : s_recal
	task automatic s_stop();
		stop_clocks = 1'b1;
		repeat (6) @(negedge ref_clk);
		check("lock while stopped", 1'b0, lnk.dll_locked);
		stop_clocks = 1'b0;
		repeat (2100) @(negedge ref_clk);
		check("lock on restart", 1'b1, lnk.dll_locked);
		dll_enable = 1'b0;
		repeat (4) @(negedge ref_clk);
		check("lock when off", 1'b0, lnk.dll_locked);
		check("ready when off", 1'b1, link_ready);
	endtask : s_stop
	// Strap is taken at start-up only, later changes do nothing
	task automatic s_single();
		do_reset(1'b1);
		repeat (10) @(negedge ref_clk);
		check("single mode", 1'b1, single_mode);
		single_clock = 1'b0;
		repeat (10) @(negedge ref_clk);
		check("strap held", 1'b1, single_mode);
	endtask : s_single
	// Main sequence
	initial begin
		do_reset(1'b0);
		s_lock();
		s_bytes();
		s_fresh();
		s_recal();
		s_stop();
		s_single();
		conclude();
	end
endmodule : dual_port_burst_sram_control_bench
`default_nettype wire
